// [src/mic_pkg.sv]
/*
 * constants shared by the interrupt controller: register offsets, field positions,
 * reset values, source order, vectors and timing counts.
 * assumes a 250 MHz machine-cycle clock and an 8-bit register port.
 */
package mic_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_ENABLE_PRIMARY    = 8'h00_A8;
  localparam logic [7:0] ADDR_ENABLE_EXTERNAL   = 8'h00_B8;
  localparam logic [7:0] ADDR_ENABLE_SERIAL_ONE = 8'h00_9A;
  localparam logic [7:0] ADDR_TIMER_EXT_FLAGS   = 8'h00_88;
  localparam logic [7:0] ADDR_EXT_REQ_FLAGS     = 8'h00_C0;
  localparam logic [7:0] ADDR_PRIORITY_LOW      = 8'h00_A9;
  localparam logic [7:0] ADDR_PRIORITY_HIGH     = 8'h00_B9;
  localparam logic [7:0] ADDR_WATCHDOG_TICK     = 8'h00_E8;
  localparam logic [7:0] ADDR_EDGE_POLARITY     = 8'h00_F8;
  localparam logic [7:0] ADDR_SERVICE_STATUS    = 8'h00_F9;

  // field positions
  localparam int GLOBAL_EN_BIT  = 7;
  localparam int SERIAL0_EN_BIT = 4;
  localparam int TIMER1_EN_BIT  = 3;
  localparam int EXT1_EN_BIT    = 2;
  localparam int TIMER0_EN_BIT  = 1;
  localparam int EXT0_EN_BIT    = 0;
  localparam int EXT_LOW_BIT    = 1;   // ext2..ext6 at bits 1..5
  localparam int SERIAL1_EN_BIT = 0;
  localparam int TF1_BIT        = 7;
  localparam int TF0_BIT        = 5;
  localparam int IE1_BIT        = 3;
  localparam int IT1_BIT        = 2;
  localparam int IE0_BIT        = 1;
  localparam int IT0_BIT        = 0;
  localparam int TICK_EN_BIT    = 0;
  localparam int TICK_FLAG_BIT  = 1;
  localparam int POL_EXT2_BIT   = 0;
  localparam int POL_EXT3_BIT   = 1;

  localparam logic [7:0] REG_RESET = 8'h00_00;

  // sources in fixed polling order; group of a source is its index halved
  localparam int NUM_SOURCES = 11;
  localparam int NUM_GROUPS  = 6;
  localparam int NUM_LEVELS  = 4;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_SER1 = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_EXT3 = 5;
  localparam int SRC_TMR1 = 6;
  localparam int SRC_EXT4 = 7;
  localparam int SRC_SER0 = 8;
  localparam int SRC_EXT5 = 9;
  localparam int SRC_EXT6 = 10;

  localparam logic [15:0] VECTOR [NUM_SOURCES] = '{
    16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};

  // timing
  localparam int CLK_MHZ       = 250;
  localparam int LCALL_CYCLES  = 6;
  localparam int TICK_PERIOD_US = 853_400;
  localparam int TICK_CYCLES   = TICK_PERIOD_US * CLK_MHZ;

endpackage : mic_pkg

// [src/mic_interrupt_controller.sv]
/*
 * eleven-source, four-level vectored interrupt controller for the 8-bit core,
 * with its flag, enable and priority registers and the periodic tick.
 * assumes a core sequencer that answers irq_request with call_taken and
 * signals return-from-interrupt with reti_done, and a plain register port.
 */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - eleven sources, flags except serial, four priority levels
// - flags set whatever the enable bits say
// - poll flags each cycle, request vectored call
// - active service preempted only by higher level
// - return ends the topmost active level
// - one detect cycle plus six call cycles
// - global enable bit blocks every interrupt
// - primary enables for serial0, timers, ext0/1
// - external enables ext2..ext6 at bits 1..5
// - serial one enable in bit zero
// - timer overflow, ext flags and types layout
// - ext2..ext6 edge flags at bits 1..5
// - timer call taken clears overflow flag, pulses acknowledge
// - ext0..5 flags auto clear, tick manual
// - ext0/ext1 from dio requests, selectable polarity
// - comparators, eeprom busy, tick feed ext2, ext4..6
// - ext4 comparator inverted, ext5 and ext6 sensed falling
// - tick every 853.4 ms, double enable
// - ext6 edge sensitive, tick flag at E8
// - type bit picks falling edge or low level
// - two priority bits per group, fixed polling
// - fixed vector address per source
module mic_interrupt_controller #(
  parameter int TICK_CYCLES = mic_pkg::TICK_CYCLES
) (
  input  wire  logic        clk,
  input  wire  logic        resetn,
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [7:0]  reg_wdata,
  input  wire  logic        reg_write,
  input  wire  logic        reg_read,
  output       logic [7:0]  reg_rdata,
  input  wire  logic        dio_high_req,
  input  wire  logic        dio_low_req,
  input  wire  logic        ext0_invert,
  input  wire  logic        ext1_invert,
  input  wire  logic        comparator2,
  input  wire  logic        comparator3,
  input  wire  logic        comparator_select,
  input  wire  logic        eeprom_busy,
  input  wire  logic        timer0_overflow,
  input  wire  logic        timer1_overflow,
  input  wire  logic        serial0_request,
  input  wire  logic        serial1_request,
  input  wire  logic        call_taken,
  input  wire  logic        reti_done,
  output       logic        irq_request,
  output       logic [15:0] irq_vector,
  output       logic        handler_entry,
  output       logic        timer0_service_ack,
  output       logic        timer1_service_ack
);

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << 28)) begin
      $error("TICK_CYCLES out of range");
    end
  end

  typedef enum logic [2:0] {
    MIC_IDLE = 3'b001,
    MIC_REQ  = 3'b010,
    MIC_CALL = 3'b100
  } mic_state_type;

  localparam int NS = mic_pkg::NUM_SOURCES;
  localparam int NA = 5;   // asynchronous pins
  localparam int NE = 6;   // falling-edge detectors

  logic [7:0]  enable_primary;
  logic [7:0]  enable_external;
  logic [7:0]  enable_serial_one;
  logic [7:0]  priority_low_bits;
  logic [7:0]  priority_high_bits;
  logic [1:0]  edge_polarity;
  logic        timer0_overflow_flag;
  logic        timer1_overflow_flag;
  logic        ext0_request_flag;
  logic        ext1_request_flag;
  logic        ext0_trigger_type;
  logic        ext1_trigger_type;
  logic [5:1]  ext_edge_flag;
  logic        tick_irq_enable;
  logic        tick_request_flag;
  logic [27:0] tick_count;
  logic        periodic_tick_source;
  logic [NA-1:0] sync1;
  logic [NA-1:0] sync2;
  logic [NA-1:0] sync3;
  logic [NA-1:0] pin_level;
  logic [NE-1:0] sense;
  logic [NE-1:0] sense_prev;
  logic [NE-1:0] fall;
  logic [NS-1:0] enable_vec;
  logic [NS-1:0] pending;
  logic [3:0]  in_service;
  logic [3:0]  top_mask;
  logic [1:0]  cur_level;
  logic        found;
  logic [3:0]  best_idx;
  logic [1:0]  best_level;
  logic        eligible;
  mic_state_type state;
  logic [3:0]  sel_idx;
  logic [1:0]  sel_level;
  logic [2:0]  call_count;
  logic        take;
  logic        wr_timer_and_external_flags;
  logic        wr_external_request_flags;
  logic        wr_tick;

  // level of a source from its group's two priority bits
  function automatic logic [1:0] level_of(input logic [3:0] idx, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [2:0] g;
    g = idx[3:1];
    level_of = {hi[g], lo[g]};
  endfunction : level_of

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a new level counts once stages two and three agree
  assign wr_timer_and_external_flags  = reg_write && reg_addr == mic_pkg::ADDR_TIMER_EXT_FLAGS;
  assign wr_external_request_flags = reg_write && reg_addr == mic_pkg::ADDR_EXT_REQ_FLAGS;
  assign wr_tick  = reg_write && reg_addr == mic_pkg::ADDR_WATCHDOG_TICK;

  genvar gi;
  generate
    for (gi = 0; gi < NA; gi++) begin : g_sync
      logic pin_raw;
      if (gi == 0) begin : g_p0
        assign pin_raw = dio_high_req;
      end else if (gi == 1) begin : g_p1
        assign pin_raw = dio_low_req;
      end else if (gi == 2) begin : g_p2
        assign pin_raw = comparator2;
      end else if (gi == 3) begin : g_p3
        assign pin_raw = comparator3;
      end else begin : g_p4
        assign pin_raw = eeprom_busy;
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          sync1[gi]     <= 1'b1;
          sync2[gi]     <= 1'b1;
          sync3[gi]     <= 1'b1;
          pin_level[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_raw;
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_level[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // every pin and the tick is turned into a signal whose falling edge means an event
  always_comb begin
    logic cmp;
    cmp = comparator_select ? pin_level[3] : pin_level[2];
    sense[0] = pin_level[0] ^ ext0_invert;
    sense[1] = pin_level[1] ^ ext1_invert;
    sense[2] = cmp ^ edge_polarity[mic_pkg::POL_EXT2_BIT];
    sense[3] = ~cmp;                                  // rising comparator
    sense[4] = pin_level[4];        // busy sensed falling, not inverted
    sense[5] = periodic_tick_source;  // tick low pulse sensed falling, not inverted
  end
  assign fall = sense_prev & ~sense;

  // history starts at the idle sense of each source, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sense_prev <= sense;   // idle sense: inverted ext4 comparator and inverts are 0 there
    end else begin
      sense_prev <= sense;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic tick: source drops low for one cycle per period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_count           <= '0;
      periodic_tick_source <= 1'b1;
    end else if (tick_count == 28'(TICK_CYCLES - 1)) begin
      tick_count           <= '0;
      periodic_tick_source <= 1'b0;
    end else begin
      tick_count           <= tick_count + 28'd1;
      periodic_tick_source <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers written by software
  always_ff @(posedge clk) begin
    if (!resetn) begin
      enable_primary     <= mic_pkg::REG_RESET;
      enable_external    <= mic_pkg::REG_RESET;
      enable_serial_one  <= mic_pkg::REG_RESET;
      priority_low_bits  <= mic_pkg::REG_RESET;
      priority_high_bits <= mic_pkg::REG_RESET;
      edge_polarity      <= '0;
      ext0_trigger_type  <= 1'b0;
      ext1_trigger_type  <= 1'b0;
      tick_irq_enable    <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == mic_pkg::ADDR_ENABLE_PRIMARY) begin
        enable_primary <= reg_wdata & 8'h00_9F;
      end else if (reg_addr == mic_pkg::ADDR_ENABLE_EXTERNAL) begin
        enable_external <= reg_wdata & 8'h00_3E;
      end else if (reg_addr == mic_pkg::ADDR_ENABLE_SERIAL_ONE) begin
        enable_serial_one <= reg_wdata & 8'h00_01;
      end else if (reg_addr == mic_pkg::ADDR_PRIORITY_LOW) begin
        priority_low_bits <= reg_wdata & 8'h00_3F;
      end else if (reg_addr == mic_pkg::ADDR_PRIORITY_HIGH) begin
        priority_high_bits <= reg_wdata & 8'h00_3F;
      end else if (reg_addr == mic_pkg::ADDR_EDGE_POLARITY) begin
        edge_polarity <= reg_wdata[1:0];   // software should leave zero
      end else if (wr_timer_and_external_flags) begin
        ext0_trigger_type <= reg_wdata[mic_pkg::IT0_BIT];
        ext1_trigger_type <= reg_wdata[mic_pkg::IT1_BIT];
      end else if (wr_tick) begin
        tick_irq_enable <= reg_wdata[mic_pkg::TICK_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags: hardware set beats software write and service clear
  always_ff @(posedge clk) begin
    logic d0;
    logic d1;
    if (!resetn) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      ext0_request_flag    <= 1'b0;
      ext1_request_flag    <= 1'b0;
    end else begin
      // type 1: falling edge; type 0: low level keeps setting
      d0 = ext0_trigger_type ? fall[0] : ~sense[0];
      d1 = ext1_trigger_type ? fall[1] : ~sense[1];
      timer0_overflow_flag <= timer0_overflow |
        ((wr_timer_and_external_flags ? reg_wdata[mic_pkg::TF0_BIT] : timer0_overflow_flag)
         & ~(take && sel_idx == 4'(mic_pkg::SRC_TMR0)));
      timer1_overflow_flag <= timer1_overflow |
        ((wr_timer_and_external_flags ? reg_wdata[mic_pkg::TF1_BIT] : timer1_overflow_flag)
         & ~(take && sel_idx == 4'(mic_pkg::SRC_TMR1)));
      ext0_request_flag <= d0 |
        ((wr_timer_and_external_flags ? reg_wdata[mic_pkg::IE0_BIT] : ext0_request_flag)
         & ~(take && sel_idx == 4'(mic_pkg::SRC_EXT0)));
      ext1_request_flag <= d1 |
        ((wr_timer_and_external_flags ? reg_wdata[mic_pkg::IE1_BIT] : ext1_request_flag)
         & ~(take && sel_idx == 4'(mic_pkg::SRC_EXT1)));
    end
  end

  // ext2..ext6 edge flags; ext3 has no source, ext6 and tick clear by software only
  always_ff @(posedge clk) begin
    logic [5:1] hw_set;
    logic [5:1] hw_clr;
    if (!resetn) begin
      ext_edge_flag     <= '0;
      tick_request_flag <= 1'b0;
    end else begin
      hw_set = {fall[5], fall[4], fall[3], 1'b0, fall[2]};
      hw_clr = '0;
      hw_clr[1] = take && sel_idx == 4'(mic_pkg::SRC_EXT2);
      hw_clr[2] = take && sel_idx == 4'(mic_pkg::SRC_EXT3);
      hw_clr[3] = take && sel_idx == 4'(mic_pkg::SRC_EXT4);
      hw_clr[4] = take && sel_idx == 4'(mic_pkg::SRC_EXT5);
      ext_edge_flag <= hw_set |
        ((wr_external_request_flags ? reg_wdata[5:1] : ext_edge_flag) & ~hw_clr);
      tick_request_flag <= fall[5] |
        (wr_tick ? reg_wdata[mic_pkg::TICK_FLAG_BIT] : tick_request_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending vector in polling order and the arbiter
  assign enable_vec = {
    enable_external[5] & tick_irq_enable,
    enable_external[4], enable_primary[mic_pkg::SERIAL0_EN_BIT],
    enable_external[3], enable_primary[mic_pkg::TIMER1_EN_BIT],
    enable_external[2], enable_primary[mic_pkg::EXT1_EN_BIT],
    enable_external[1], enable_primary[mic_pkg::TIMER0_EN_BIT],
    enable_serial_one[mic_pkg::SERIAL1_EN_BIT], enable_primary[mic_pkg::EXT0_EN_BIT]};

  assign pending = enable_vec & {
    ext_edge_flag[5] & tick_request_flag, ext_edge_flag[4], serial0_request,
    ext_edge_flag[3], timer1_overflow_flag, ext_edge_flag[2], ext1_request_flag,
    ext_edge_flag[1], timer0_overflow_flag, serial1_request, ext0_request_flag};

  // lowest index wins among equal levels, hence the downward scan
  always_comb begin
    found      = 1'b0;
    best_idx   = '0;
    best_level = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pending[i] && (!found || level_of(4'(i), priority_low_bits, priority_high_bits)
                         >= best_level)) begin
        found      = 1'b1;
        best_idx   = 4'(i);
        best_level = level_of(4'(i), priority_low_bits, priority_high_bits);
      end
    end
  end

  // topmost active service level
  always_comb begin
    top_mask  = '0;
    cur_level = '0;
    for (int l = 0; l < mic_pkg::NUM_LEVELS; l++) begin
      if (in_service[l]) begin
        top_mask  = 4'(1 << l);
        cur_level = 2'(l);
      end
    end
  end

  assign eligible = enable_primary[mic_pkg::GLOBAL_EN_BIT] && found &&
                    (in_service == '0 || best_level > cur_level);
  assign take = state == MIC_REQ && call_taken;

  ////////////////////////////////////////////////////////////////////////////
  // request sequencer: detect, request, then count the forced call
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state       <= MIC_IDLE;
      irq_request <= 1'b0;
      irq_vector  <= '0;
      sel_idx     <= '0;
      sel_level   <= '0;
      call_count  <= '0;
    end else begin
      case (state)
        MIC_IDLE: begin
          if (eligible) begin
            state       <= MIC_REQ;
            irq_request <= 1'b1;
            irq_vector  <= mic_pkg::VECTOR[best_idx];
            sel_idx     <= best_idx;
            sel_level   <= best_level;
          end
        end
        MIC_REQ: begin
          if (call_taken) begin
            state       <= MIC_CALL;
            irq_request <= 1'b0;
            call_count  <= 3'd1;
          end else if (!eligible || best_idx != sel_idx) begin
            state       <= MIC_IDLE;   // re-poll when the winner changes
            irq_request <= 1'b0;
          end
        end
        MIC_CALL: begin
          if (call_count == 3'(mic_pkg::LCALL_CYCLES - 1)) begin
            state <= MIC_IDLE;
          end else begin
            call_count <= call_count + 3'd1;
          end
        end
        default: begin
          state       <= MIC_IDLE;
          irq_request <= 1'b0;
        end
      endcase
    end
  end

  // service levels and the entry and acknowledge pulses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_service         <= '0;
      handler_entry      <= 1'b0;
      timer0_service_ack <= 1'b0;
      timer1_service_ack <= 1'b0;
    end else begin
      in_service <= (in_service & ~(reti_done ? top_mask : 4'h0_0))
                    | (take ? 4'(1 << sel_level) : 4'h0_0);
      handler_entry <= state == MIC_CALL &&
                       call_count == 3'(mic_pkg::LCALL_CYCLES - 1);
      timer0_service_ack <= take && sel_idx == 4'(mic_pkg::SRC_TMR0);
      timer1_service_ack <= take && sel_idx == 4'(mic_pkg::SRC_TMR1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (!reg_read) begin
      reg_rdata <= '0;
    end else if (reg_addr == mic_pkg::ADDR_ENABLE_PRIMARY) begin
      reg_rdata <= enable_primary;
    end else if (reg_addr == mic_pkg::ADDR_ENABLE_EXTERNAL) begin
      reg_rdata <= enable_external;
    end else if (reg_addr == mic_pkg::ADDR_ENABLE_SERIAL_ONE) begin
      reg_rdata <= enable_serial_one;
    end else if (reg_addr == mic_pkg::ADDR_TIMER_EXT_FLAGS) begin
      reg_rdata <= {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
                    ext1_request_flag, ext1_trigger_type,
                    ext0_request_flag, ext0_trigger_type};
    end else if (reg_addr == mic_pkg::ADDR_EXT_REQ_FLAGS) begin
      reg_rdata <= {2'b00, ext_edge_flag, 1'b0};
    end else if (reg_addr == mic_pkg::ADDR_PRIORITY_LOW) begin
      reg_rdata <= priority_low_bits;
    end else if (reg_addr == mic_pkg::ADDR_PRIORITY_HIGH) begin
      reg_rdata <= priority_high_bits;
    end else if (reg_addr == mic_pkg::ADDR_WATCHDOG_TICK) begin
      reg_rdata <= {6'b00_0000, tick_request_flag, tick_irq_enable};
    end else if (reg_addr == mic_pkg::ADDR_EDGE_POLARITY) begin
      reg_rdata <= {6'b00_0000, edge_polarity};
    end else if (reg_addr == mic_pkg::ADDR_SERVICE_STATUS) begin
      reg_rdata <= {4'h0, in_service};
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_global_gate: assert property ($rose(irq_request) |->
    $past(enable_primary[mic_pkg::GLOBAL_EN_BIT]))
    else $error("request raised with global enable off");
  a_flag_set_wins: assert property (timer0_overflow |=> timer0_overflow_flag)
    else $error("timer0 overflow flag not set");
  a_entry_latency: assert property (take |-> ##6 handler_entry)
    else $error("handler entry not six cycles after call");
  a_timer_ack: assert property ((take && sel_idx == 4'd2) |=>
    timer0_service_ack ##1 !timer0_service_ack)
    else $error("timer0 acknowledge not a single pulse");
  a_preempt_level: assert property ((take && in_service != 4'h0) |->
    sel_level > cur_level)
    else $error("call taken at no higher level");
  a_reti_pop: assert property ((reti_done && !take) |=>
    in_service == ($past(in_service) & ~$past(top_mask)))
    else $error("return did not end top level");
  a_tick_manual: assert property ((tick_request_flag && !wr_tick) |=>
    tick_request_flag)
    else $error("tick flag cleared by hardware");
  a_tick_pulse: assert property ((tick_count == 28'(TICK_CYCLES - 1)) |=>
    !periodic_tick_source ##1 periodic_tick_source)
    else $error("tick source pulse wrong");
  a_busy_falling: assert property (fall[4] |=> ext_edge_flag[4])
    else $error("eeprom busy fall not flagged");
  a_request_vector: assert property ($rose(irq_request) |->
    irq_vector == mic_pkg::VECTOR[sel_idx])
    else $error("vector does not match source");

  c_call_taken: cover property (take);
  c_nested_call: cover property (take && in_service != 4'h0);
  c_reti: cover property (reti_done && in_service != 4'h0);
  c_tick_call: cover property (take && sel_idx == 4'd10);

endmodule : mic_interrupt_controller

// [tb/mic_core_model.sv]
/* core sequencer stand-in: takes irq_request after a set delay, relays returns.
   assumes the controller's clock and synchronous active-low reset. */
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       irq_request,
  input  wire logic [3:0] delay,
  input  wire logic       reti_cmd,
  output      logic       call_taken,
  output      logic       reti_done
);
  logic [3:0] cnt;
  // a slow take makes the request stand; restart if it is withdrawn
  always_ff @(posedge clk) begin
    if (!resetn || !irq_request || call_taken) begin
      cnt        <= 4'h0;
      call_taken <= 1'h0;
    end else begin
      cnt        <= cnt + 4'h1;
      call_taken <= (cnt == delay);
    end
  end
  // return instruction executed on command
  always_ff @(posedge clk) reti_done <= resetn & reti_cmd;
endmodule : mic_core_model

// [tb/mic_interrupt_controller_tb.sv]
/* bench: notes expectations in queues; a watcher compares results as they appear.
   assumes the core model answers calls; tick period kept beyond the run. */
`timescale 1ns/1ps
module mic_interrupt_controller_tb;
  localparam logic [7:0] EN0 = mic_pkg::ADDR_ENABLE_PRIMARY;
  localparam logic [7:0] EN1 = mic_pkg::ADDR_ENABLE_EXTERNAL;
  localparam logic [7:0] EN2 = mic_pkg::ADDR_ENABLE_SERIAL_ONE;
  localparam logic [7:0] TFL = mic_pkg::ADDR_TIMER_EXT_FLAGS;
  localparam logic [7:0] XFL = mic_pkg::ADDR_EXT_REQ_FLAGS;
  logic        clk = 0, resetn = 0, reg_write = 0, reg_read = 0, t0 = 0, t1 = 0;
  logic        reti_cmd = 0, rd_seen = 0, call_taken, reti_done, irq_request;
  logic        handler_entry, ack0, ack1;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, r;
  logic [4:0]  pins = '1;  // dio high, dio low, comparator 2, 3, eeprom busy
  logic [3:0]  delay = 0;
  logic [4:0]  side = 0;  // ext0, ext1 invert, comparator select, serial0, serial1
  logic [15:0] irq_vector, last_vec;
  logic [7:0]  q8[$];
  logic [15:0] q16[$];
  int          num_errors = 0, comparisons = 0, lat = 0, seed = 8;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  mic_interrupt_controller #(.TICK_CYCLES(60000)) DUT (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .dio_high_req(pins[4]),
    .dio_low_req(pins[3]), .ext0_invert(side[4]), .ext1_invert(side[3]),
    .comparator2(pins[2]), .comparator3(pins[1]), .comparator_select(side[2]),
    .eeprom_busy(pins[0]), .timer0_overflow(t0), .timer1_overflow(t1),
    .serial0_request(side[1]), .serial1_request(side[0]), .call_taken(call_taken),
    .reti_done(reti_done), .irq_request(irq_request), .irq_vector(irq_vector),
    .handler_entry(handler_entry), .timer0_service_ack(ack0), .timer1_service_ack(ack1));
  mic_core_model core (.clk(clk), .resetn(resetn), .irq_request(irq_request),
    .delay(delay), .reti_cmd(reti_cmd), .call_taken(call_taken), .reti_done(reti_done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (exp !== got) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one-cycle strobes with a gap, so no signal is assigned twice at one edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    q8.push_back(e);
    @(posedge clk);
    reg_read <= 1'h0;
  endtask : rd
  task automatic tmr(logic a, logic b);
    @(posedge clk);
    t0 <= a;
    t1 <= b;
    @(posedge clk);
    t0 <= 1'h0;
    t1 <= 1'h0;
  endtask : tmr
  task automatic reti;
    @(posedge clk);
    reti_cmd <= 1'h1;
    @(posedge clk);
    reti_cmd <= 1'h0;
  endtask : reti
  // bounded wait: a missing entry counts once and the run goes on
  task automatic wait_entry;
    repeat (40) begin
      @(posedge clk);
      if (handler_entry === 1'h1) return;
    end
    check("entry", 16'h0001, 16'h0000);
  endtask : wait_entry
  task automatic print_verdict;
    $display("counts: %0d mismatches, %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // watcher: read data the cycle after a read, vector at the take, then timing
  always @(posedge clk) begin
    if (rd_seen) check("read data", {8'h00, q8.pop_front()}, {8'h00, reg_rdata});
    rd_seen <= reg_read;
    if (irq_request === 1'h1 && call_taken === 1'h1) begin
      check("vector", q16.pop_front(), irq_vector);
      last_vec <= irq_vector;
      lat      <= 1;
    end else if (lat != 0) lat <= lat + 1;
    if (handler_entry === 1'h1) check("latency", 16'h0006, 16'(lat));
    if ((ack0 | ack1) === 1'h1) begin
      check("ack time", 16'h0001, 16'(lat));
      check("ack", (last_vec == 16'h001B) ? 16'h0002 : 16'h0001, {14'h0, ack1, ack0});
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    rd(EN0, 8'h00);
    rd(TFL, 8'h00);
    rd(XFL, 8'h00);
    rd(8'h55, 8'h00);
    $display("test reset done");
    r = 8'($random(seed));
    wr(EN0, 8'h9F);
    rd(EN0, 8'h9F);
    wr(EN1, r);
    rd(EN1, r & 8'h3E);
    wr(EN2, 8'h01);
    rd(EN2, 8'h01);
    wr(EN0, 8'h00);
    wr(EN1, 8'h00);
    wr(EN2, 8'h00);
    $display("test enables done");
    // timers, ext0, ext1, ext2 and ext5 fire with enables off; ext2 kept at its falling reset polarity
    // comparator three selected: only its fall may set ext2, comparator two stays high
    pins <= 5'b0_0100;
    side[2] <= 1'h1;
    tmr(1'h1, 1'h1);
    repeat (8) @(posedge clk);
    rd(TFL, 8'hAA);
    rd(XFL, 8'h12);
    pins <= '1;
    repeat (8) @(posedge clk);
    wr(TFL, 8'h00);
    wr(XFL, 8'h00);
    $display("test flags done");
    // equal level: timer0 polled first, timer1 waits for the return, slow take
    wr(EN0, 8'h8A);
    q16.push_back(16'h000B);
    q16.push_back(16'h001B);
    tmr(1'h1, 1'h1);
    wait_entry;
    repeat (10) @(posedge clk);
    check("waiting", 16'h0000, {15'h0, irq_request});
    delay <= 4'h3;
    reti;
    wait_entry;
    reti;
    rd(TFL, 8'h00);
    $display("test calls done");
    // global enable off: the flag stands but nothing is requested
    wr(EN0, 8'h0A);
    tmr(1'h1, 1'h0);
    repeat (10) @(posedge clk);
    check("global off", 16'h0000, {15'h0, irq_request});
    rd(TFL, 8'h20);
    $display("test global done");
    // timer0 flag left standing serves at level 0; serial one at level 1 preempts it
    wr(mic_pkg::ADDR_PRIORITY_LOW, 8'h01);
    wr(EN2, 8'h01);
    q16.push_back(16'h000B);
    q16.push_back(16'h0083);
    wr(EN0, 8'h82);
    wait_entry;
    side[0] <= 1'h1;
    wait_entry;
    side[0] <= 1'h0;
    rd(mic_pkg::ADDR_SERVICE_STATUS, 8'h03);
    reti;
    reti;
    rd(mic_pkg::ADDR_SERVICE_STATUS, 8'h00);
    $display("test nesting done");
    print_verdict();
  end
  // watchdog well past the fewer than two hundred cycles the tests need
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule : mic_interrupt_controller_tb
